// ==== system_clock_divisor_pll.sv ====
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module system_clock_divisor_pll (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // axi4-lite write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [clock_divisor_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic [2:0] awprot_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [clock_divisor_pkg::DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // axi4-lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // axi4-lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [clock_divisor_pkg::ADDR_W-1:0] araddr_i,
  input wire logic [2:0] arprot_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [clock_divisor_pkg::DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  // oscillator ticks, one cycle each, from the analog sources
  input wire logic fast_rc_tick_i,
  input wire logic primary_tick_i,
  input wire logic low_power_rc_tick_i,
  input wire logic pll_out_tick_i,
  // any interrupt request to the processor
  input wire logic irq_i,
  // derived clock ticks
  output logic sys_osc_tick_o,
  output logic instr_tick_o,
  output logic proc_tick_o,
  output logic periph_tick_o,
  // pll factors to the analog core
  output clock_divisor_pkg::pll_factors_s pll_factors_o
);
  import clock_divisor_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // decoding shared by the read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = (addr == CLOCK_DIVISOR_OFFSET) || (addr == CLOCK_SELECT_OFFSET) ||
      (addr == PLL_FEEDBACK_OFFSET) || (addr == CLOCK_STATUS_OFFSET);
  endfunction : is_mapped

  // terminal count of the rc postscaler; code 111 jumps to 255, a divide by 256
  function automatic logic [7:0] rc_post_last(input logic [2:0] code);
    if (code == 3'h7) begin
      rc_post_last = 8'hFF;
    end else begin
      rc_post_last = 8'((9'h001 << code) - 9'h001);
    end
  endfunction : rc_post_last

  // terminal count of the processor reduction counter, power of two
  function automatic logic [6:0] reduce_last(input logic [2:0] code);
    reduce_last = 7'((8'h01 << code) - 8'h01);
  endfunction : reduce_last

  // merge write data into a word under the byte strobes
  function automatic logic [15:0] strobe_merge(input logic [15:0] cur,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
    strobe_merge = cur;
    if (strb[0]) begin
      strobe_merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      strobe_merge[15:8] = data[15:8];
    end
  endfunction : strobe_merge

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic awready;
  logic wready;
  logic arready;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic [DATA_W-1:0] rd_word;

  clock_divisor_s clock_divisor;
  clock_divisor_s next_clock_divisor;
  logic [2:0] clock_select;
  logic [8:0] pll_feedback_div;

  logic [7:0] rc_post_cnt;
  logic rc_post_evt;
  logic instr_phase;
  logic sel_tick;
  logic instr_evt;
  logic [6:0] reduce_cnt;
  logic reduce_evt;

  //////////////////////////////////////////////////////////////////////////////
  // write address and data are taken independently, in either order
  assign do_write = !awready && !wready && !bvalid_o;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      awready <= 1'b1;
      wr_addr <= '0;
    end else if (awvalid_i && awready) begin
      awready <= 1'b0;
      wr_addr <= awaddr_i;
    end else if (bvalid_o && bready_i) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wready <= 1'b1;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid_i && wready) begin
      wready <= 1'b0;
      wr_data <= wdata_i;
      wr_strb <= wstrb_i;
    end else if (bvalid_o && bready_i) begin
      wready <= 1'b1;
    end
  end

  // response one cycle after both halves are held; unmapped gets slverr
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_o <= 1'b1;
      bresp_o <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  assign awready_o = awready;
  assign wready_o = wready;
  assign arready_o = arready;

  //////////////////////////////////////////////////////////////////////////////
  // read path: data registered at the address handshake
  always_comb begin
    rd_word = '0;
    unique case (araddr_i)
      CLOCK_DIVISOR_OFFSET: rd_word[15:0] = clock_divisor;
      CLOCK_SELECT_OFFSET: rd_word[2:0] = clock_select;
      PLL_FEEDBACK_OFFSET: rd_word[8:0] = pll_feedback_div;
      CLOCK_STATUS_OFFSET: begin
        rd_word[2:0] = clock_select;
        rd_word[3] = clock_divisor.proc_clock_reduce_en;
        rd_word[6:4] = clock_divisor.proc_clock_reduce_en ?
          clock_divisor.proc_clock_reduce_sel : REDUCE_SEL_NONE;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      arready <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= RESP_OKAY;
    end else if (arvalid_i && arready) begin
      arready <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= rd_word;
      rresp_o <= is_mapped(araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_o && rready_i) begin
      arready <= 1'b1;
      rvalid_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock divisor update; the interrupt recovery overrides a same-cycle set
  // so the processor is never left slowed after it was told to recover
  always_comb begin
    logic [15:0] merged;
    merged = strobe_merge(clock_divisor, wr_data, wr_strb);
    next_clock_divisor = clock_divisor;
    if (do_write && (wr_addr == CLOCK_DIVISOR_OFFSET)) begin
      next_clock_divisor.recover_on_irq = merged[RECOVER_ON_IRQ_BIT];
      next_clock_divisor.rc_osc_postscale = merged[RC_POSTSCALE_LSB +: 3];
      next_clock_divisor.pll_output_postscale = merged[OUTPUT_POSTSCALE_LSB +: 2];
      next_clock_divisor.pll_input_prescale = merged[INPUT_PRESCALE_LSB +: 5];
      if (!clock_divisor.proc_clock_reduce_en) begin
        next_clock_divisor.proc_clock_reduce_sel = merged[REDUCE_SEL_LSB +: 3];
      end
      if (merged[REDUCE_EN_BIT] && (next_clock_divisor.proc_clock_reduce_sel == REDUCE_SEL_NONE))
      begin
        next_clock_divisor.proc_clock_reduce_en = 1'b0;
      end else begin
        next_clock_divisor.proc_clock_reduce_en = merged[REDUCE_EN_BIT];
      end
    end
    if (irq_i && clock_divisor.recover_on_irq) begin
      next_clock_divisor.proc_clock_reduce_en = 1'b0;
    end
    next_clock_divisor.unused = 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clock_divisor <= CLOCK_DIVISOR_RESET;
    end else begin
      clock_divisor <= next_clock_divisor;
    end
  end

  // source select; codes beyond the six sources are dropped
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clock_select <= CLOCK_SELECT_RESET;
    end else if (do_write && (wr_addr == CLOCK_SELECT_OFFSET) && wr_strb[0] &&
                 (wr_data[2:0] <= SRC_LOW_POWER_RC)) begin
      clock_select <= wr_data[2:0];
    end
  end

  // pll feedback divider, nine bits over two byte lanes
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pll_feedback_div <= PLL_FEEDBACK_RESET;
    end else if (do_write && (wr_addr == PLL_FEEDBACK_OFFSET)) begin
      pll_feedback_div <= 9'(strobe_merge({7'h00, pll_feedback_div}, wr_data, wr_strb));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pll factors; the analog core forms vco = in*M/N1 and divides it by N2
  // after, so the postscaler never loads the vco term
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pll_factors_o <= '0;
    end else begin
      pll_factors_o.feedback_mult <= {1'b0, pll_feedback_div} + FEEDBACK_OFFSET;
      pll_factors_o.pre_divide_factor <=
        {1'b0, clock_divisor.pll_input_prescale} + PRESCALE_OFFSET;
      // code 10 is reserved; it still follows the formula rather than guess
      pll_factors_o.post_divide_factor <=
        4'({2'h0, clock_divisor.pll_output_postscale} + POSTSCALE_OFFSET) << 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // rc postscaler counts fast rc ticks up to its terminal count
  assign rc_post_evt = fast_rc_tick_i &&
    (rc_post_cnt >= rc_post_last(clock_divisor.rc_osc_postscale));

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rc_post_cnt <= '0;
    end else if (rc_post_evt) begin
      rc_post_cnt <= '0;
    end else if (fast_rc_tick_i) begin
      rc_post_cnt <= rc_post_cnt + 8'h01;
    end
  end

  // system oscillator tick from the selected source
  always_comb begin
    unique case (clock_source_e'(clock_select))
      SRC_FAST_RC: sel_tick = fast_rc_tick_i;
      SRC_FAST_RC_PLL: sel_tick = pll_out_tick_i;
      SRC_FAST_RC_POST: sel_tick = rc_post_evt;
      SRC_PRIMARY: sel_tick = primary_tick_i;
      SRC_PRIMARY_PLL: sel_tick = pll_out_tick_i;
      SRC_LOW_POWER_RC: sel_tick = low_power_rc_tick_i;
      default: sel_tick = fast_rc_tick_i;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // instruction clock at half the oscillator rate
  assign instr_evt = sel_tick && (instr_phase == INSTR_PHASE_LAST);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      instr_phase <= 1'b0;
    end else if (sel_tick) begin
      instr_phase <= ~instr_phase;
    end
  end

  // processor reduction counts instruction ticks; cleared when disabled so
  // a fresh enable starts a whole period
  assign reduce_evt = instr_evt &&
    (reduce_cnt >= reduce_last(clock_divisor.proc_clock_reduce_sel));

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reduce_cnt <= '0;
    end else if (!clock_divisor.proc_clock_reduce_en || reduce_evt) begin
      reduce_cnt <= '0;
    end else if (instr_evt) begin
      reduce_cnt <= reduce_cnt + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tick outputs, registered, one cycle late against their cause
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sys_osc_tick_o <= 1'b0;
      instr_tick_o <= 1'b0;
      periph_tick_o <= 1'b0;
      proc_tick_o <= 1'b0;
    end else begin
      sys_osc_tick_o <= sel_tick;
      instr_tick_o <= instr_evt;
      periph_tick_o <= instr_evt;
      proc_tick_o <= clock_divisor.proc_clock_reduce_en ? reduce_evt : instr_evt;
    end
  end

endmodule : system_clock_divisor_pll

// ==== clock_divisor_pkg.sv ====
package clock_divisor_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus geometry and answers
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // byte offsets of the register words
  localparam logic [7:0] CLOCK_DIVISOR_OFFSET = 8'h00;
  localparam logic [7:0] CLOCK_SELECT_OFFSET = 8'h04;
  localparam logic [7:0] PLL_FEEDBACK_OFFSET = 8'h08;
  localparam logic [7:0] CLOCK_STATUS_OFFSET = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // clock divisor field positions
  localparam int unsigned RECOVER_ON_IRQ_BIT = 15;
  localparam int unsigned REDUCE_SEL_LSB = 12;
  localparam int unsigned REDUCE_EN_BIT = 11;
  localparam int unsigned RC_POSTSCALE_LSB = 8;
  localparam int unsigned OUTPUT_POSTSCALE_LSB = 6;
  localparam int unsigned UNUSED_BIT = 5;
  localparam int unsigned INPUT_PRESCALE_LSB = 0;

  typedef struct packed {
    logic recover_on_irq;
    logic [2:0] proc_clock_reduce_sel;
    logic proc_clock_reduce_en;
    logic [2:0] rc_osc_postscale;
    logic [1:0] pll_output_postscale;
    logic unused;
    logic [4:0] pll_input_prescale;
  } clock_divisor_s;

  // reduction by 8 selected but not enabled, and pll postscale by 4 after reset
  localparam logic [15:0] CLOCK_DIVISOR_RESET = 16'h3040;
  localparam logic [2:0] REDUCE_SEL_NONE = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // system clock sources
  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'h0,
    SRC_FAST_RC_PLL = 3'h1,
    SRC_FAST_RC_POST = 3'h2,
    SRC_PRIMARY = 3'h3,
    SRC_PRIMARY_PLL = 3'h4,
    SRC_LOW_POWER_RC = 3'h5
  } clock_source_e;
  localparam logic [2:0] CLOCK_SELECT_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // pll factors handed to the analog core
  localparam logic [8:0] PLL_FEEDBACK_RESET = 9'h030;
  localparam logic [9:0] FEEDBACK_OFFSET = 10'h002;
  localparam logic [5:0] PRESCALE_OFFSET = 6'h02;
  localparam logic [3:0] POSTSCALE_OFFSET = 4'h1;

  typedef struct packed {
    logic [9:0] feedback_mult;
    logic [5:0] pre_divide_factor;
    logic [3:0] post_divide_factor;
  } pll_factors_s;

  // instruction clock phase count: one instruction per two oscillator ticks
  localparam logic INSTR_PHASE_LAST = 1'b1;

endpackage : clock_divisor_pkg

// ==== system_clock_divisor_pll_asserts.sv ====
`timescale 1ns/1ps
module system_clock_divisor_pll_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register bus answers
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  // oscillator ticks in
  input wire logic fast_rc_tick_i,
  input wire logic primary_tick_i,
  input wire logic low_power_rc_tick_i,
  input wire logic pll_out_tick_i,
  // derived ticks and pll factors
  input wire logic sys_osc_tick_o,
  input wire logic instr_tick_o,
  input wire logic proc_tick_o,
  input wire logic periph_tick_o,
  input wire clock_divisor_pkg::pll_factors_s pll_factors_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [1:0] sys_count;
  ////////////////////////////////////////////////////////////////////////////
  // sys ticks seen since the last instruction tick; saturates so a stuck divider shows
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) sys_count <= 2'h0;
    else if (instr_tick_o) sys_count <= {1'b0, sys_osc_tick_o};
    else if (sys_osc_tick_o && sys_count != 2'h3) sys_count <= sys_count + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_instr_rate: assert property (sys_count <= 2'h2)
    else $error("instruction tick missed after two sys ticks");
  a_instr_cause: assert property (instr_tick_o |-> sys_count != 2'h0 || sys_osc_tick_o)
    else $error("instruction tick without sys tick");
  a_periph_same: assert property (periph_tick_o == instr_tick_o)
    else $error("peripheral tick differs from instruction tick");
  a_proc_on_instr: assert property (proc_tick_o |-> instr_tick_o)
    else $error("processor tick off the instruction grid");
  a_sys_cause: assert property (sys_osc_tick_o |->
    $past(fast_rc_tick_i | primary_tick_i | low_power_rc_tick_i | pll_out_tick_i))
    else $error("sys tick without any oscillator tick");
  a_factors_legal: assert property (!$past(reset_i) |->
    pll_factors_o.post_divide_factor[0] == 1'b0 && pll_factors_o.pre_divide_factor >= 6'h02 &&
    pll_factors_o.feedback_mult >= 10'h002)
    else $error("pll factor below its offset");
  a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped early");
  a_read_busy: assert property (rvalid_o |-> !arready_o)
    else $error("read address accepted while answer pending");
  c_proc: cover property (proc_tick_o && !$past(proc_tick_o));
  c_write: cover property (bvalid_o && bready_i);
  c_read: cover property (rvalid_o && rready_i);
endmodule : system_clock_divisor_pll_asserts

bind system_clock_divisor_pll system_clock_divisor_pll_asserts i_asserts (.core_clk_i, .reset_i,
  .bvalid_o, .bready_i, .bresp_o, .arready_o, .rvalid_o, .rready_i, .rdata_o, .fast_rc_tick_i,
  .primary_tick_i, .low_power_rc_tick_i, .pll_out_tick_i, .sys_osc_tick_o, .instr_tick_o,
  .proc_tick_o, .periph_tick_o, .pll_factors_o);

// ==== system_clock_divisor_pll_tb_top.sv ====
`timescale 1ns/1ps
module system_clock_divisor_pll_tb_top;
  import clock_divisor_pkg::*;
  logic core_clk_i = 1'b0, reset_i = 1'b1, irq_i = 1'b0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic fast_rc_tick_i = 1'b0, primary_tick_i = 1'b0, low_power_rc_tick_i = 1'b0;
  logic pll_out_tick_i = 1'b0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic sys_osc_tick_o, instr_tick_o, proc_tick_o, periph_tick_o;
  pll_factors_s pll_factors_o;
  int failures = 0;
  int tests_run = 0;
  int ns, ni, np, npr;
  logic [31:0] d;
  logic [1:0] r;

  // protection bits are not decoded, so they stay tied
  system_clock_divisor_pll i_system_clock_divisor_pll (.core_clk_i, .reset_i, .awvalid_i,
    .awready_o, .awaddr_i, .awprot_i(3'h0), .wvalid_i, .wready_o, .wdata_i, .wstrb_i(4'hF),
    .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i, .arprot_i(3'h0),
    .rvalid_o, .rready_i, .rdata_o, .rresp_o, .fast_rc_tick_i, .primary_tick_i,
    .low_power_rc_tick_i, .pll_out_tick_i, .irq_i, .sys_osc_tick_o, .instr_tick_o,
    .proc_tick_o, .periph_tick_o, .pll_factors_o);

  // 50 MHz core clock
  always #10 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // address and data offered together, each released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    awvalid_i <= 1'b1;
    awaddr_i <= a;
    wvalid_i <= 1'b1;
    wdata_i <= {16'h0000, v};
    bready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awvalid_i && awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o === 1'b1) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    arvalid_i <= 1'b1;
    araddr_i <= a;
    rready_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arvalid_i && arready_o === 1'b1) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
  endtask : rd

  // ticks never land on adjacent cycles; six idle cycles let the pipeline drain
  task automatic run(input int n);
    ns = 0;
    ni = 0;
    np = 0;
    npr = 0;
    for (int k = 0; k < n + 6; k++) begin
      @(posedge core_clk_i);
      ns += int'(sys_osc_tick_o === 1'b1);
      ni += int'(instr_tick_o === 1'b1);
      np += int'(periph_tick_o === 1'b1);
      npr += int'(proc_tick_o === 1'b1);
      fast_rc_tick_i <= k < n && k % 2 == 0;
      primary_tick_i <= k < n && k % 3 == 0;
      low_power_rc_tick_i <= k < n && k % 4 == 0;
      pll_out_tick_i <= k < n && k % 6 == 0;
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'h00);
    chk(d, 16'h3040);
    rd(8'h08);
    chk(d, 16'h0030);
    chk(32'(pll_factors_o), {12'h000, 10'h032, 6'h02, 4'h4});
    wr(8'h10, 16'h1234);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(8'h10);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask : t_reset

  task automatic t_fields;
    wr(8'h00, 16'h0020);
    rd(8'h00);
    chk(d, 16'h0000);
    wr(8'h00, 16'h0800);
    rd(8'h00);
    chk(d, 16'h0000);
    wr(8'h00, 16'h2800);
    wr(8'h00, 16'h5000);
    rd(8'h00);
    chk(d, 16'h2000);
  endtask : t_fields

  task automatic t_pll;
    wr(8'h08, 16'h0100);
    foreach (d[p]) if (p < 4 && p != 2) begin
      wr(8'h00, 16'(p * 64 + 5));
      @(posedge core_clk_i);
      chk(32'(pll_factors_o), {12'h000, 10'h102, 6'h07, 4'(2 * (p + 1))});
      chk(32'(pll_factors_o.pre_divide_factor), 32'h0000_0007);
    end
  endtask : t_pll

  // reduction counter restarts on enable, so 64 instruction ticks give exact counts
  task automatic t_reduce;
    wr(8'h00, 16'h0000);
    run(256);
    chk(ns, 128);
    chk(ni, 64);
    chk(np, 64);
    chk(npr, 64);
    for (int s = 1; s < 8; s++) begin
      wr(8'h00, 16'(s * 4096));
      wr(8'h00, 16'(s * 4096 + 2048));
      run(256);
      chk(npr, 64 >> s);
    end
  endtask : t_reduce

  task automatic t_irq;
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 16'h3000);
      wr(8'h00, k ? 16'h3800 : 16'hB800);
      @(posedge core_clk_i);
      irq_i <= 1'b1;
      @(posedge core_clk_i);
      irq_i <= 1'b0;
      rd(8'h00);
      chk(d, k ? 16'h3800 : 16'hB000);
    end
    // status shows the source, the enable and the reduction now in force
    rd(8'h0C);
    chk(d, 32'h0000_0038);
  endtask : t_irq

  // each oscillator input gets its own tick count over the window
  task automatic t_sources;
    int exp_src[6] = '{24, 8, 24, 16, 8, 12};
    wr(8'h00, 16'h3000);
    for (int s = 0; s < 6; s++) begin
      wr(8'h04, 16'(s));
      run(48);
      chk(ns, exp_src[s]);
    end
    wr(8'h00, 16'h3200);
    wr(8'h04, 16'h0002);
    run(48);
    chk(ns, 6);
    // a code past the six sources must leave the selection alone
    wr(8'h04, 16'h0007);
    rd(8'h04);
    chk(d, 32'h0000_0002);
  endtask : t_sources

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // whole sequence needs about 2700 cycles; allow far more
  initial begin
    #1_000_000;
    failures++;
    results();
  end

  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_fields();
    t_pll();
    t_reduce();
    t_irq();
    t_sources();
    results();
  end
endmodule : system_clock_divisor_pll_tb_top
